// ===== logic/mctpu_timer_pulse_unit.sv
/*
 Six-channel 16-bit timer: counting, compare output, capture,
 synchronous preset/clear and buffer operation on channels 0 and 3.
 Assumes pin inputs and software strobes are synchronous to CLOCK.
*/
`default_nettype none
// Function
// - After reset every counter is free-running with no clearing source.
// - Setting a start bit makes the counter advance on its count clock.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow flag with its enable raises the channel interrupt.
// - After overflow the counter keeps counting from zero.
// - Match with selected clearing sets match flag and zeroes counter.
// - Match or capture flag with its enable raises the interrupt.
// - Compare match drives the pin low, high or toggled per setting.
// - A match asking for the present level leaves the pin alone.
// - Selected pin edge copies the counter into the general register.
// - Channels 0,1,3,4 may capture on another channel's clock or match.
// - Capture selected as clearing source zeroes the counter at capture.
// - Counter write in sync mode loads all synchronised channels.
// - Sync-cleared channels clear with another synchronised channel.
// - All six channels can join synchronous operation.
// - Only channels 0 and 3 buffer: C buffers A, D buffers B.
// - Buffered compare match moves buffer into its general register.
// - Buffered capture moves old register value into the buffer.
// - Stopping the counter keeps the pin at its compare level.
module mctpu_timer_pulse_unit (
    input  wire logic                                CLOCK,
    input  wire logic                                SYS_RST,
    input  wire logic [mctpu_pkg::NCH-1:0]           START_CONTROL,
    input  wire logic [mctpu_pkg::NCH-1:0]           SYNC_SELECT,
    input  wire mctpu_pkg::mctpu_chcfg_type [5:0]    CHANNEL_CONTROL,
    input  wire mctpu_pkg::mctpu_wr_type             COUNTER_WRITE,
    input  wire mctpu_pkg::mctpu_wr_type             GR_WRITE,
    input  wire mctpu_pkg::mctpu_flags_type [5:0]    FLAG_CLEAR,
    input  wire logic [5:0][1:0]                     PIN_IN,
    output logic [5:0][1:0]                          PIN_OUT,
    output logic [5:0][1:0]                          PIN_OE,
    output logic [5:0][15:0]                         CHANNEL_COUNTER,
    output logic [5:0][3:0][15:0]                    GENERAL_REGISTER,
    output mctpu_pkg::mctpu_flags_type [5:0]         CHANNEL_STATUS,
    output logic [mctpu_pkg::NCH-1:0]                IRQ
);
    import mctpu_pkg::*;

    // The undivided select ticks every clock; divided ones wait for prescaler ones
    // Tick of a count clock select; unknown selects never tick
    function automatic logic tick_of(input logic [2:0] sel, input logic [5:0] pre);
        logic t;
        t = 1'b0;
        unique case (sel)
            CLK_DIV1:  t = 1'b1;
            CLK_DIV4:  t = (pre & MASK_DIV4) == MASK_DIV4;
            CLK_DIV16: t = (pre & MASK_DIV16) == MASK_DIV16;
            CLK_DIV64: t = (pre & MASK_DIV64) == MASK_DIV64;
            default:   t = 1'b0;
        endcase
        return t;
    endfunction

    // Edge or cross-channel capture trigger
    function automatic logic cap_hit(input logic [1:0] m, input logic p,
                                     input logic c, input logic x);
        logic h;
        h = 1'b0;
        unique case (m)
            CAP_RISE: h = ~p & c;
            CAP_FALL: h = p & ~c;
            CAP_BOTH: h = p ^ c;
            CAP_XCH:  h = x;
        endcase
        return h;
    endfunction

    // Pin level after a compare match
    function automatic logic pin_next(input logic [1:0] m, input logic lvl);
        logic n;
        n = lvl;
        unique case (m)
            IO_OFF:  n = lvl;
            IO_LOW:  n = 1'b0;
            IO_HIGH: n = 1'b1;
            IO_TOG:  n = ~lvl;
        endcase
        return n;
    endfunction

    // One free prescaler feeds every divided count clock, so channels on the
    // same ratio always tick together; synchronous operation relies on that
    logic [PRE_W-1:0]     pre_reg;
    logic [5:0][15:0]     cnt_reg, cnt_next;
    logic [5:0][3:0][15:0] gr_reg, gr_next;
    logic [5:0][1:0]      lvl_reg, lvl_next;
    logic [5:0][1:0]      prev_reg;
    mctpu_flags_type [5:0] flag_reg, flag_next;

    // Per-channel event wires; slot 0 of a pair is pin A and slot 1 pin B
    logic [5:0]      ch_tick, cnt_en, ovf, clr_own, clr_do, bufm, xtrig, cnt_wr_hit;
    logic [5:0][1:0] is_cap, cmp, cap, ev, out_on;
    logic            sync_clr_any, cnt_wr_sync;

    // Sync preset: a write to a synchronised channel reaches all of them
    // Writes naming channels 6 and 7 are dropped, never aliased
    assign cnt_wr_sync = COUNTER_WRITE.chan < 3'(NCH) &&
                         SYNC_SELECT[COUNTER_WRITE.chan[2:0]];
    // Any synchronised channel clearing by its own source drags the group
    assign sync_clr_any = |(clr_own & SYNC_SELECT);

    genvar i, j;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            mctpu_chcfg_type cfg;
            assign cfg = CHANNEL_CONTROL[i];
            // Count enable only on the selected tick while started
            assign ch_tick[i] = tick_of(cfg.clk_sel, pre_reg);
            assign cnt_en[i]  = START_CONTROL[i] & ch_tick[i];
            assign ovf[i]     = cnt_en[i] & (cnt_reg[i] == CNT_MAX);
            assign bufm[i]    = cfg.buf_en & BUF_CH[i];

            // Cross-channel capture sources exist only on 0,1,3,4
            if (i % 3 == 0) begin : g_xclk
                // The undivided clock is refused as a capture source
                assign xtrig[i] = ch_tick[i+1] &
                                  (CHANNEL_CONTROL[i+1].clk_sel != CLK_DIV1);
            end else if (i % 3 == 1) begin : g_xcmp
                assign xtrig[i] = cmp[i-1][GR_A];
            end else begin : g_xnone
                assign xtrig[i] = 1'b0;
            end

            // A capture-mode pin never drives, so the unit never fights the
            // external source on that wire
            for (j = 0; j < 2; j++) begin : g_pin
                assign is_cap[i][j] = cfg.pin_io_control[j][IO_CAP_BIT];
                assign out_on[i][j] = ~is_cap[i][j] &
                                      (cfg.pin_io_control[j][1:0] != IO_OFF);
                // Compare is only evaluated on a count tick
                assign cmp[i][j] = cnt_en[i] & ~is_cap[i][j] &
                                   (cnt_reg[i] == gr_reg[i][j]);
                assign cap[i][j] = is_cap[i][j] &
                                   cap_hit(cfg.pin_io_control[j][1:0], prev_reg[i][j],
                                           PIN_IN[i][j], xtrig[i] & XCAP_CH[i]);
                assign ev[i][j]  = cmp[i][j] | cap[i][j];

                // Hardware events win over a software write in the same cycle
                assign gr_next[i][j] =
                    cap[i][j] ? cnt_reg[i] :
                    (cmp[i][j] & bufm[i]) ? gr_reg[i][j+BUF_OFS] :
                    (GR_WRITE.en && GR_WRITE.chan == 3'(i) && GR_WRITE.sel == 2'(j)) ?
                        GR_WRITE.data : gr_reg[i][j];
                // Buffers exist only on buffer-capable channels
                assign gr_next[i][j+BUF_OFS] =
                    (cap[i][j] & bufm[i]) ? gr_reg[i][j] :
                    (BUF_CH[i] && GR_WRITE.en && GR_WRITE.chan == 3'(i) &&
                     GR_WRITE.sel == 2'(j + BUF_OFS)) ? GR_WRITE.data :
                        gr_reg[i][j+BUF_OFS];

                // Level holds between matches, so a stopped counter keeps it
                assign lvl_next[i][j] = (cmp[i][j] & out_on[i][j]) ?
                    pin_next(cfg.pin_io_control[j][1:0], lvl_reg[i][j]) :
                    lvl_reg[i][j];
                assign PIN_OE[i][j] = out_on[i][j];

                // Set wins over clear so no event is lost
                assign flag_next[i].match_capture_flag[j] = ev[i][j] |
                    (flag_reg[i].match_capture_flag[j] &
                     ~FLAG_CLEAR[i].match_capture_flag[j]);
            end

            assign flag_next[i].overflow_flag = ovf[i] |
                (flag_reg[i].overflow_flag & ~FLAG_CLEAR[i].overflow_flag);

            // Own clearing by match or capture of the selected register
            assign clr_own[i] = (cfg.clear_source_field == CLR_GRA & ev[i][GR_A]) |
                                (cfg.clear_source_field == CLR_GRB & ev[i][GR_B]);
            assign clr_do[i]  = clr_own[i] |
                                (cfg.clear_source_field == CLR_SYNC & SYNC_SELECT[i] &
                                 sync_clr_any);
            assign cnt_wr_hit[i] = COUNTER_WRITE.en &
                                   (COUNTER_WRITE.chan == 3'(i) |
                                    (SYNC_SELECT[i] & cnt_wr_sync));

            // Write, then clear, then count; the 16-bit add wraps to zero
            assign cnt_next[i] = cnt_wr_hit[i] ? COUNTER_WRITE.data :
                                 clr_do[i] ? CNT_ZERO :
                                 cnt_en[i] ? 16'(cnt_reg[i] + 16'h0001) :
                                 cnt_reg[i];

            // Interrupt is a level from sticky flags; it drops on a flag clear or when its enable is removed
            assign IRQ[i] = (flag_reg[i].overflow_flag & cfg.overflow_irq_enable) |
                            |(flag_reg[i].match_capture_flag &
                              cfg.match_capture_irq_enable);
        end
    endgenerate

    // Prescaler runs free so all channels share tick phase
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= PRE_W'(pre_reg + 6'h01);
        end
    end

    // All channel state in one place; reset config is zero, free-running
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cnt_reg  <= '0;
            gr_reg   <= {24{GR_RESET}};
            lvl_reg  <= '0;
            prev_reg <= '0;
            flag_reg <= '0;
        end else begin
            cnt_reg  <= cnt_next;
            gr_reg   <= gr_next;
            lvl_reg  <= lvl_next;
            prev_reg <= PIN_IN;
            flag_reg <= flag_next;
        end
    end

    assign PIN_OUT          = lvl_reg;
    assign CHANNEL_COUNTER  = cnt_reg;
    assign GENERAL_REGISTER = gr_reg;
    assign CHANNEL_STATUS   = flag_reg;

    // Checks watch the channels that each bench scenario drives, so every
    // antecedent below is reached at least once
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    ovf_wrap_a: assert property (
        ovf[2] && !cnt_wr_hit[2] && !clr_do[2] |=> cnt_reg[2] == CNT_ZERO &&
        flag_reg[2].overflow_flag) else $error("overflow did not wrap and flag");
    count_step_a: assert property (
        cnt_en[1] && !cnt_wr_hit[1] && !clr_do[1] |=>
        cnt_reg[1] == 16'($past(cnt_reg[1]) + 16'h0001)) else $error("count step wrong");
    stop_hold_a: assert property (
        !START_CONTROL[1] && !cnt_wr_hit[1] && !clr_do[1] |=>
        $stable(cnt_reg[1]) && $stable(lvl_reg[1])) else $error("stopped channel moved");
    match_clear_a: assert property (
        cmp[0][GR_A] && CHANNEL_CONTROL[0].clear_source_field == CLR_GRA &&
        !cnt_wr_hit[0] |=> cnt_reg[0] == CNT_ZERO &&
        flag_reg[0].match_capture_flag[GR_A]) else $error("match clear missing");
    pin_level_a: assert property (
        cmp[1][GR_B] && out_on[1][GR_B] &&
        CHANNEL_CONTROL[1].pin_io_control[GR_B][1:0] == IO_HIGH |=>
        PIN_OUT[1][GR_B]) else $error("pin not driven high");
    cap_copy_a: assert property (
        cap[4][GR_A] |=> gr_reg[4][GR_A] == $past(cnt_reg[4]))
        else $error("capture value wrong");
    buf_cap_a: assert property (
        cap[0][GR_B] && bufm[0] |=> gr_reg[0][GR_D] == $past(gr_reg[0][GR_B]))
        else $error("buffer not loaded on capture");
    buf_cmp_a: assert property (
        cmp[3][GR_A] && bufm[3] |=> gr_reg[3][GR_A] == $past(gr_reg[3][GR_C]))
        else $error("buffer not moved on match");
    sync_preset_a: assert property (
        COUNTER_WRITE.en && cnt_wr_sync && SYNC_SELECT[5] |=>
        cnt_reg[5] == $past(COUNTER_WRITE.data)) else $error("sync preset missed");
    flag_stick_a: assert property (
        flag_reg[2].overflow_flag && !FLAG_CLEAR[2].overflow_flag |=>
        flag_reg[2].overflow_flag) else $error("flag dropped without clear");
    irq_flag_a: assert property (
        flag_reg[1].match_capture_flag[GR_A] &&
        CHANNEL_CONTROL[1].match_capture_irq_enable[GR_A] |-> IRQ[1])
        else $error("interrupt missing");

    // Overflow interrupt follows its flag and enable
    ovf_irq_a: assert property (
        flag_reg[2].overflow_flag && CHANNEL_CONTROL[2].overflow_irq_enable |-> IRQ[2])
        else $error("overflow interrupt missing");

    // No flag set means no request from that channel
    irq_quiet_a: assert property (
        flag_reg[1] == '0 |-> !IRQ[1])
        else $error("interrupt without flag");

    // Capture chosen as clearing source zeroes the counter
    cap_clear_a: assert property (
        cap[4][GR_A] && CHANNEL_CONTROL[4].clear_source_field == CLR_GRA &&
        !cnt_wr_hit[4] |=> cnt_reg[4] == CNT_ZERO) else $error("capture clear missing");

    // Capture raises its flag one edge later
    cap_flag_a: assert property (
        cap[4][GR_A] |=> flag_reg[4].match_capture_flag[GR_A])
        else $error("capture flag missing");

    // Compare flag is set together with its action
    match_flag_a: assert property (
        cmp[1][GR_B] |=> flag_reg[1].match_capture_flag[GR_B])
        else $error("match flag missing");

    // Toggle setting inverts the level at each match
    tog_pin_a: assert property (
        cmp[1][GR_A] && out_on[1][GR_A] &&
        CHANNEL_CONTROL[1].pin_io_control[GR_A][1:0] == IO_TOG |=>
        PIN_OUT[1][GR_A] != $past(PIN_OUT[1][GR_A])) else $error("pin did not toggle");

    // Group clearing reaches a sync-cleared channel
    sync_clear_a: assert property (
        sync_clr_any && SYNC_SELECT[5] && CHANNEL_CONTROL[5].clear_source_field == CLR_SYNC &&
        !cnt_wr_hit[5] |=> cnt_reg[5] == CNT_ZERO) else $error("sync clear missed");

    // Counter write beats clear and count
    write_pri_a: assert property (
        cnt_wr_hit[0] |=> cnt_reg[0] == $past(COUNTER_WRITE.data))
        else $error("counter write lost");

    // Plain register write lands when no event competes
    gr_write_a: assert property (
        GR_WRITE.en && GR_WRITE.chan == 3'h3 && GR_WRITE.sel == 2'(GR_A) &&
        !cap[3][GR_A] && !cmp[3][GR_A] |=> gr_reg[3][GR_A] == $past(GR_WRITE.data))
        else $error("register write lost");

    // Channels without buffers ignore writes to slot C
    no_buf_a: assert property (
        GR_WRITE.en && GR_WRITE.chan == 3'h1 && GR_WRITE.sel == 2'(GR_C) |=>
        $stable(gr_reg[1][GR_C])) else $error("buffer on unbuffered channel");

    // Other-channel capture on channel 1 comes from channel 0 match A
    xcap_src_a: assert property (
        cap[1][GR_A] && CHANNEL_CONTROL[1].pin_io_control[GR_A][1:0] == CAP_XCH |->
        cmp[0][GR_A]) else $error("cross capture without source");

    // A capture pin is never driven
    oe_mode_a: assert property (
        is_cap[4][GR_A] |-> !PIN_OE[4][GR_A])
        else $error("capture pin driven");

    ovf_seen_c: cover property (ovf[2] ##1 IRQ[2]);
    sync_clr_c: cover property (sync_clr_any && clr_do[5] && !clr_own[5]);
    toggle_c: cover property (cmp[1][GR_A] && out_on[1][GR_A]);
    xcap_c: cover property (cap[1][GR_A] && xtrig[1]);
    cap_buf_c: cover property (cap[0][GR_B] && bufm[0]);
endmodule // mctpu_timer_pulse_unit
`default_nettype wire

// ===== logic/mctpu_pkg.sv
/*
 Constants, field layouts and carrier types for the six-channel timer unit.
 Assumes one 10 MHz clock and plain configuration ports, no register bus.
*/
`default_nettype none
package mctpu_pkg;
    localparam int NCH = 6;
    localparam int CW  = 16;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] GR_RESET = 16'hFFFF;
    // Count clock selects and the prescaler masks that make their ticks
    localparam logic [2:0] CLK_DIV1  = 3'h0;
    localparam logic [2:0] CLK_DIV4  = 3'h1;
    localparam logic [2:0] CLK_DIV16 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam int PRE_W = 6;
    localparam logic [5:0] MASK_DIV4  = 6'h03;
    localparam logic [5:0] MASK_DIV16 = 6'h0F;
    localparam logic [5:0] MASK_DIV64 = 6'h3F;
    // Counter clearing sources
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_GRA  = 3'h1;
    localparam logic [2:0] CLR_GRB  = 3'h2;
    localparam logic [2:0] CLR_SYNC = 3'h3;
    // Pin setting: bit 3 picks capture, low bits pick action or edge
    localparam int IO_CAP_BIT = 3;
    localparam logic [1:0] IO_OFF  = 2'h0;
    localparam logic [1:0] IO_LOW  = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOG  = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
    localparam logic [1:0] CAP_XCH  = 2'h3;
    // General register slots; C and D buffer A and B
    localparam int GR_A = 0;
    localparam int GR_B = 1;
    localparam int GR_C = 2;
    localparam int GR_D = 3;
    localparam int BUF_OFS = 2;
    localparam logic [5:0] BUF_CH  = 6'h09;
    localparam logic [5:0] XCAP_CH = 6'h1B;

    typedef struct packed {
        logic [2:0]      clk_sel;
        logic [2:0]      clear_source_field;
        logic [1:0][3:0] pin_io_control;
        logic            buf_en;
        logic            overflow_irq_enable;
        logic [1:0]      match_capture_irq_enable;
    } mctpu_chcfg_type;

    typedef struct packed {
        logic       en;
        logic [2:0] chan;
        logic [1:0] sel;
        logic [15:0] data;
    } mctpu_wr_type;

    typedef struct packed {
        logic       overflow_flag;
        logic [1:0] match_capture_flag;
    } mctpu_flags_type;
endpackage
`default_nettype wire

// ===== tb/mctpu_pin_model.sv
/*
 Far-side model of the timer pins: holds an external level per pin and
 loops the unit's own level back where the unit drives the wire.
 Assumes flip requests are synchronous to the bench clock.
*/
`default_nettype none
module mctpu_pin_model (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic [5:0][1:0] flip,
    input  wire logic [5:0][1:0] pin_out,
    input  wire logic [5:0][1:0] pin_oe,
    output logic [5:0][1:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0][1:0] level_reg;
    // Level moves only on request, so every capture edge is one we asked for
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_reg <= '0;
        end else begin
            level_reg <= level_reg ^ flip;
        end
    end
    // A driven pin shows the unit's level on the wire
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & level_reg);
endmodule // mctpu_pin_model
`default_nettype wire

// ===== tb/mctpu_timer_pulse_unit_bench.sv
/*
 Self-checking bench: counting, compare output, capture, sync and buffer.
 Assumes the pin model beside it and one 10 MHz clock.
*/
`default_nettype none
module mctpu_timer_pulse_unit_bench;
    import mctpu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1;
    logic [5:0] run = '0, sync = '0, irq;
    mctpu_chcfg_type [5:0] cfg = '0;
    mctpu_wr_type cw = '0, gw = '0;
    mctpu_flags_type [5:0] fc = '0, st;
    logic [5:0][1:0] pin_in, pout, poe, flip = '0;
    logic [5:0][15:0] cnt;
    logic [5:0][3:0][15:0] gr;
    int error_cnt = 0, checked = 0, seed = 95, n, i, m, e, v, exp_gr;
    logic hit;
    always #50 clk = ~clk;
    mctpu_timer_pulse_unit mctpu_timer_pulse_unit_inst (.CLOCK(clk), .SYS_RST(rst),
        .START_CONTROL(run), .SYNC_SELECT(sync), .CHANNEL_CONTROL(cfg), .COUNTER_WRITE(cw),
        .GR_WRITE(gw), .FLAG_CLEAR(fc), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe),
        .CHANNEL_COUNTER(cnt), .GENERAL_REGISTER(gr), .CHANNEL_STATUS(st), .IRQ(irq));
    mctpu_pin_model mctpu_pin_model_inst (.clk(clk), .sys_rst(rst), .flip(flip),
        .pin_out(pout), .pin_oe(poe), .pin_in(pin_in));
    task conclude();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, s, x);
        end
    endtask
    // Bounded wait for a flag; b 2 is overflow, 0 and 1 the match flags
    task wflag(input int ch, input int b);
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (b == 2 ? st[ch].overflow_flag === 1'b1 : st[ch].match_capture_flag[b] === 1'b1)
                break;
        end
        if (i == 3000) begin
            error_cnt++;
            $display("Error at %0t: flag wait ran out", $time);
            conclude();
        end
    endtask
    task clr(input int ch);
        @(posedge clk) fc[ch] <= '1;
        @(posedge clk) fc[ch] <= '0;
        #1;
    endtask
    // Writes are only issued to stopped channels, so the extra edge is harmless
    task wcnt(input int ch, input logic [15:0] d);
        @(posedge clk) cw <= '{1'b1, 3'(ch), 2'h0, d};
        @(posedge clk) cw.en <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task wgr(input int ch, input int sel, input logic [15:0] d);
        @(posedge clk) gw <= '{1'b1, 3'(ch), 2'(sel), d};
        @(posedge clk) gw.en <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task flp(input int ch, input int j);
        @(posedge clk) flip[ch][j] <= 1'b1;
        @(posedge clk) flip[ch][j] <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        for (m = 0; m < 6; m++) begin
            chk(cnt[m], CNT_ZERO);
            chk(gr[m][0], GR_RESET);
            chk(16'(st[m]), 16'h0000);
        end
        $display("Test reset done");
        // Free run through the wrap on channel 2
        cfg[2].overflow_irq_enable <= 1'b1;
        wcnt(2, 16'hFFFD);
        @(posedge clk) run[2] <= 1'b1;
        wflag(2, 2);
        chk(cnt[2], CNT_ZERO);
        chk(16'(irq[2]), 16'h0001);
        @(posedge clk);
        #1;
        chk(cnt[2], 16'h0001);
        chk(16'(st[2].overflow_flag), 16'h0001);
        clr(2);
        chk(16'(irq[2]), 16'h0000);
        $display("Test free run done");
        // Periodic count on channel 1: toggle on A, high then low on B
        n = 5 + ($unsigned($random(seed)) % 16);
        wgr(1, GR_A, 16'(n));
        wgr(1, GR_B, 16'h0002);
        wgr(1, GR_C, 16'h0000);
        chk(gr[1][GR_C], GR_RESET);
        @(posedge clk) cfg[1] <= '{CLK_DIV1, CLR_GRA, {4'h2, 4'h3}, 1'b0, 1'b0, 2'h1};
        run[1] <= 1'b1;
        wflag(1, 0);
        chk(cnt[1], CNT_ZERO);
        chk(16'(irq[1]), 16'h0001);
        chk(16'(pout[1]), 16'h0003);
        clr(1);
        chk(16'(irq[1]), 16'h0000);
        wflag(1, 0);
        chk(16'(pout[1]), 16'h0002);
        @(posedge clk) cfg[1].pin_io_control[1] <= {2'h0, IO_LOW};
        clr(1);
        wflag(1, 0);
        chk(16'(pout[1]), 16'h0001);
        // Stop mid-count: count and pins hold
        @(posedge clk) run[1] <= 1'b0;
        @(posedge clk);
        #1;
        v = cnt[1];
        m = pout[1];
        repeat (40) @(posedge clk);
        #1;
        chk(cnt[1], 16'(v));
        chk(16'(pout[1]), 16'(m));
        chk(16'(poe[1]), 16'h0003);
        n = v;
        $display("Test compare done");
        // Capture on channel 4 pin A for each edge choice, clearing at capture
        exp_gr = GR_RESET;
        @(posedge clk) run[4] <= 1'b1;
        for (m = 0; m < 3; m++) begin
            @(posedge clk) cfg[4] <= '{CLK_DIV64, CLR_GRA, {4'h0, 2'h2, 2'(m)}, 1'b0, 1'b0, 2'h0};
            for (e = 0; e < 2; e++) begin
                v = cnt[4];
                for (i = 0; i < 100 && cnt[4] === 16'(v); i++) begin
                    @(posedge clk);
                    #1;
                end
                if (i == 100) begin
                    error_cnt++;
                    $display("Error at %0t: tick wait ran out", $time);
                    conclude();
                end
                v = cnt[4];
                flp(4, 0);
                repeat (4) @(posedge clk);
                #1;
                hit = (m == CAP_BOTH) || (m == CAP_RISE && e == 0) || (m == CAP_FALL && e == 1);
                if (hit) exp_gr = v;
                chk(gr[4][GR_A], 16'(exp_gr));
                chk(cnt[4], hit ? CNT_ZERO : 16'(v));
            end
        end
        $display("Test capture done");
        // Sync preset and clear on channels 0 and 5; ch0 uses a divided clock
        @(posedge clk) sync <= 6'h21;
        wcnt(0, 16'h0100);
        chk(cnt[5], 16'h0100);
        wgr(0, GR_A, 16'h0110);
        @(posedge clk) cfg[0] <= '{CLK_DIV4, CLR_GRA, {4'h0, 4'h3}, 1'b0, 1'b0, 2'h0};
        cfg[5] <= '{CLK_DIV4, CLR_SYNC, 8'h00, 1'b0, 1'b0, 2'h0};
        run[0] <= 1'b1;
        run[5] <= 1'b1;
        wflag(0, 0);
        chk(cnt[5], CNT_ZERO);
        chk(cnt[0], CNT_ZERO);
        // Channel 1 captures on channel 0 match A while stopped
        @(posedge clk) cfg[1] <= '{CLK_DIV1, CLR_NONE, {4'h0, 1'b1, 1'b0, CAP_XCH}, 1'b0, 1'b0, 2'h0};
        clr(1);
        wflag(1, 0);
        chk(gr[1][GR_A], 16'(n));
        $display("Test sync done");
        // Buffered compare on channel 3, buffered capture on channel 0 pin B
        wgr(3, GR_A, 16'h0020);
        wgr(3, GR_C, 16'h0040);
        @(posedge clk) cfg[3] <= '{CLK_DIV1, CLR_NONE, {4'h0, 4'h3}, 1'b1, 1'b0, 2'h0};
        run[3] <= 1'b1;
        wflag(3, 0);
        chk(gr[3][GR_A], 16'h0040);
        v = $unsigned($random(seed)) & 16'h7FFF;
        @(posedge clk) run[0] <= 1'b0;
        wgr(0, GR_B, 16'(v));
        e = cnt[0];
        @(posedge clk) cfg[0] <= '{CLK_DIV4, CLR_NONE, {4'h8, 4'h0}, 1'b1, 1'b0, 2'h0};
        clr(0);
        flp(0, 1);
        wflag(0, 1);
        chk(gr[0][GR_D], 16'(v));
        chk(gr[0][GR_B], 16'(e));
        $display("Test buffer done");
        conclude();
    end
endmodule // mctpu_timer_pulse_unit_bench
`default_nettype wire
